/* hdl/cgsr_regs_top.sv */
// Serial target front end and output control of the clock generator config bank
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (R01) Byte 1 bits 7:6 read the latched spread strap: 00 low, 01 mid, 11 high.
// (R02) Byte 1 bit 5 enables software spread control, reset 0.
// (R03) With override off, soft select bits are ignored; spread follows the strap.
// (R04) Soft select: 00 off, 01 -0.25%, 10 reserved, 11 -0.5%; reset 00.
// (R05) Byte 1 bits 1:0 select amplitude 0.6/0.7/0.8/0.9V; reset 10.
// (R06) Byte 2 holds one slew bit per differential output, 1 fast, reset 1.
// (R07) Byte 3 bits 7:6 select reference slew, reset 01.
// (R08) Byte 3 bit 5 keeps reference running in power down, reset 0.
// (R09) Byte 3 bit 4 enables reference output, reset 1; 0 forces it low.
// (R10) Byte 7 bits 4:0 set block read byte count, reset 8.
// (R11) Byte 5 is fixed revision and vendor identifiers.
// (R12) Byte 6 is fixed device type and device identifier.
// (R13) Block write: address, index, count, data bytes up to the count, each acknowledged by us.
// (R14) Block read: index write, repeated start, count then data; host NACK ends.
// (R15) Target address comes from the address strap latched at power good.
// (R16) Writes to reserved bits and byte 4 are ignored; reads give fixed values.
module cgsr_regs_top import cgsr_pkg::*; #(
	parameter logic [6:0] TARGET_ADDR_STRAP_LO = 7'h30, // Address with strap low
	parameter logic [6:0] TARGET_ADDR_STRAP_HI = 7'h31 // Address with strap high
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial bus pins, open drain data
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Straps and power good
	input wire logic targetAddressStrap,
	input wire logic [1:0] spreadStrapLevel,
	input wire logic powerGoodPowerdownInput,
	// Analog control outputs
	output logic [1:0] spreadSel,
	output logic [1:0] amplitudeSel,
	output logic [NUM_DIFF-1:0] diffSlewFast,
	output logic [1:0] refSlewSel,
	output logic refRunning
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	cgsr_state_e state_reg;
	cgsr_state_e afterAck_reg;
	logic [3:0] bitCnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] pointer_reg;
	logic [7:0] remain_reg;
	logic txFirst_reg;
	logic sdaOe_reg;
	logic sdaOut_reg;
	logic strapDone_reg;
	logic addrSel_reg;
	logic [1:0] spreadStrap_reg;
	logic [1:0] spreadSel_reg;
	logic [1:0] amplitudeSel_reg;
	logic [NUM_DIFF-1:0] diffSlewFast_reg;
	logic [1:0] refSlewSel_reg;
	logic refRunning_reg;

	logic sclRise, sclFall, startSeen, stopSeen;
	logic byteDone, addrHit, loadTx, wrEn;
	logic [6:0] myAddr;
	logic [7:0] rdData;
	logic [7:0] txByte;

	logic spreadSoftwareOverrideEn;
	logic [1:0] spreadSoftSelect;
	logic [1:0] amplitudeField;
	logic [NUM_DIFF-1:0] diffSlewField;
	logic [1:0] refSlewField;
	logic wakeOnLanEn;
	logic refOutputEn;
	logic [4:0] blockReadLengthField;

	////////////////////////////////////////////////////////////////////////////////
	// Submodules

	// Pin event detection
	cgsr_bus_edges uEdges (
		.clk(clk),
		.reset(reset),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.sclRise(sclRise),
		.sclFall(sclFall),
		.startSeen(startSeen),
		.stopSeen(stopSeen)
	);

	// Register bank
	cgsr_reg_file uRegs (
		.clk(clk),
		.reset(reset),
		.wrEn(wrEn),
		.wrIdx(pointer_reg),
		.wrData(shift_reg),
		.rdIdx(pointer_reg),
		.rdData(rdData),
		.spreadStrapReadback(spreadStrap_reg),
		.spreadSoftwareOverrideEn(spreadSoftwareOverrideEn),
		.spreadSoftSelect(spreadSoftSelect),
		.amplitudeField(amplitudeField),
		.diffSlewField(diffSlewField),
		.refSlewField(refSlewField),
		.wakeOnLanEn(wakeOnLanEn),
		.refOutputEn(refOutputEn),
		.blockReadLengthField(blockReadLengthField)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Strap capture

	// Straps caught once, at the first power good
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strapDone_reg <= 1'b0;
			addrSel_reg <= 1'b0;
			spreadStrap_reg <= 2'h0;
		end else if (!strapDone_reg && powerGoodPowerdownInput) begin
			strapDone_reg <= 1'b1;
			addrSel_reg <= targetAddressStrap; // (R15)
			spreadStrap_reg <= spreadStrapLevel; // (R01)
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial target

	// Shared decode terms
	assign myAddr = addrSel_reg ? TARGET_ADDR_STRAP_HI : TARGET_ADDR_STRAP_LO; // (R15)
	assign byteDone = sclFall && bitCnt_reg == BITS_PER_BYTE;
	assign addrHit = strapDone_reg && shift_reg[7:1] == myAddr;
	assign loadTx = sclFall && ((state_reg == ST_ACK && afterAck_reg == ST_TX) ||
		state_reg == ST_TXNEXT);
	assign wrEn = byteDone && state_reg == ST_WDATA && remain_reg != 8'h00; // (R13)
	assign txByte = txFirst_reg ? {3'h0, blockReadLengthField} : rdData; // (R14)

	// Protocol state, bit counter and shifter
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			afterAck_reg <= ST_IDLE;
			bitCnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			txFirst_reg <= 1'b1;
		end else if (startSeen) begin
			state_reg <= ST_ADDR;
			bitCnt_reg <= 4'h0;
			txFirst_reg <= 1'b1;
		end else if (stopSeen) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA: begin
					if (sclRise && bitCnt_reg != BITS_PER_BYTE) begin
						shift_reg <= {shift_reg[6:0], sdaIn};
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end else if (byteDone) begin
						bitCnt_reg <= 4'h0;
						state_reg <= ST_ACK;
						case (state_reg)
							ST_ADDR: begin
								if (!addrHit) begin
									state_reg <= ST_WAIT;
								end
								afterAck_reg <= shift_reg[0] ? ST_TX : ST_INDEX; // (R14)
							end
							ST_INDEX: afterAck_reg <= ST_COUNT; // (R13)
							ST_COUNT: afterAck_reg <= ST_WDATA;
							default: begin
								if (remain_reg == 8'h00) begin
									state_reg <= ST_WAIT;
								end
								afterAck_reg <= ST_WDATA;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (loadTx) begin
						shift_reg <= txByte;
						state_reg <= ST_TX;
					end else if (sclFall) begin
						state_reg <= afterAck_reg;
					end
				end
				ST_TX: begin
					if (sclRise) begin
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end else if (byteDone) begin
						bitCnt_reg <= 4'h0;
						txFirst_reg <= 1'b0;
						state_reg <= ST_HOSTACK;
					end else if (sclFall) begin
						shift_reg <= {shift_reg[6:0], 1'b0};
					end
				end
				ST_HOSTACK: begin
					if (sclRise) begin
						state_reg <= sdaIn ? ST_WAIT : ST_TXNEXT; // (R14)
					end
				end
				ST_TXNEXT: begin
					if (loadTx) begin
						shift_reg <= txByte;
						state_reg <= ST_TX;
					end
				end
				ST_IDLE, ST_WAIT: state_reg <= state_reg;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Index pointer and remaining write count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pointer_reg <= 8'h00;
			remain_reg <= 8'h00;
		end else if (byteDone && state_reg == ST_INDEX) begin
			pointer_reg <= shift_reg; // (R13)
		end else if (byteDone && state_reg == ST_COUNT) begin
			remain_reg <= shift_reg;
		end else if (wrEn) begin
			pointer_reg <= pointer_reg + 8'h01;
			remain_reg <= remain_reg - 8'h01;
		end else if (byteDone && state_reg == ST_TX && !txFirst_reg) begin
			pointer_reg <= pointer_reg + 8'h01; // (R14)
		end
	end

	// Data pin drive: low for ack and for zero data bits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sdaOe_reg <= 1'b0;
			sdaOut_reg <= 1'b0;
		end else if (startSeen || stopSeen) begin
			sdaOe_reg <= 1'b0;
		end else if (byteDone && state_reg != ST_TX) begin
			sdaOe_reg <= (state_reg == ST_ADDR) ? addrHit : // (R13)
				(state_reg != ST_WDATA || remain_reg != 8'h00);
		end else if (loadTx) begin
			sdaOe_reg <= ~txByte[7];
		end else if (sclFall && state_reg == ST_TX) begin
			sdaOe_reg <= byteDone ? 1'b0 : ~shift_reg[6];
		end else if (sclFall && state_reg == ST_ACK) begin
			sdaOe_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output control

	// Registered analog controls
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			spreadSel_reg <= 2'h0;
			amplitudeSel_reg <= AMP_RST;
			diffSlewFast_reg <= {NUM_DIFF{DIFF_SLEW_RST}};
			refSlewSel_reg <= REF_SLEW_RST;
			refRunning_reg <= 1'b0;
		end else begin
			spreadSel_reg <= spreadSoftwareOverrideEn ? spreadSoftSelect : // (R02)
				spreadStrap_reg; // (R03)
			amplitudeSel_reg <= amplitudeField; // (R05)
			diffSlewFast_reg <= diffSlewField; // (R06)
			refSlewSel_reg <= refSlewField; // (R07)
			refRunning_reg <= refOutputEn && (powerGoodPowerdownInput || wakeOnLanEn); // (R08)
		end
	end

	assign sdaOut = sdaOut_reg;
	assign sdaOe = sdaOe_reg;
	assign spreadSel = spreadSel_reg;
	assign amplitudeSel = amplitudeSel_reg;
	assign diffSlewFast = diffSlewFast_reg;
	assign refSlewSel = refSlewSel_reg;
	assign refRunning = refRunning_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_addr_hit;
		byteDone && state_reg == ST_ADDR && addrHit;
	endsequence
	sequence s_host_nack;
		state_reg == ST_HOSTACK && sclRise && sdaIn && !startSeen && !stopSeen;
	endsequence
	sequence s_amp_write;
		wrEn && pointer_reg == IDX_SPREAD_AMP;
	endsequence

	a_ack_addr: assert property (@(posedge clk) disable iff (reset) // (R13)
		s_addr_hit |=> sdaOe_reg && state_reg == ST_ACK)
		else $error("address match not acknowledged");
	a_nack_ends: assert property (@(posedge clk) disable iff (reset) // (R14)
		s_host_nack |=> state_reg == ST_WAIT && !sdaOe_reg)
		else $error("host nack did not end the read");
	a_count_first: assert property (@(posedge clk) disable iff (reset) // (R10)
		(loadTx && txFirst_reg) |=> shift_reg == {3'h0, $past(blockReadLengthField)})
		else $error("block read did not start with byte count");
	a_soft_spread: assert property (@(posedge clk) disable iff (reset) // (R02)
		spreadSoftwareOverrideEn |=> spreadSel == $past(spreadSoftSelect))
		else $error("override did not pass soft select");
	a_strap_spread: assert property (@(posedge clk) disable iff (reset) // (R03)
		!spreadSoftwareOverrideEn |=> spreadSel == $past(spreadStrap_reg))
		else $error("spread did not follow strap");
	a_amp_write: assert property (@(posedge clk) disable iff (reset) // (R05)
		s_amp_write |-> ##2 amplitudeSel == $past(shift_reg[AMP_HI:AMP_LO], 2))
		else $error("amplitude write not applied");
	a_ref_gate: assert property (@(posedge clk) disable iff (reset) // (R09)
		!refOutputEn |=> !refRunning)
		else $error("reference running while disabled");
	a_wol_run: assert property (@(posedge clk) disable iff (reset) // (R08)
		(refOutputEn && wakeOnLanEn) |=> refRunning)
		else $error("reference stopped with wake enabled");
	a_ident_fixed: assert property (@(posedge clk) disable iff (reset) // (R11)
		(loadTx && !txFirst_reg && pointer_reg == IDX_REV_VENDOR) |=>
			shift_reg == {uRegs.REV_IDENT, uRegs.VENDOR_IDENT})
		else $error("revision byte not sent as fixed");
	a_strap_held: assert property (@(posedge clk) disable iff (reset) // (R15)
		$past(strapDone_reg) |-> $stable(addrSel_reg) && $stable(spreadStrap_reg))
		else $error("strap followed after latch");
	a_rsvd_read: assert property (@(posedge clk) disable iff (reset) // (R16)
		(loadTx && !txFirst_reg && pointer_reg == IDX_RSVD_FOUR) |=> shift_reg == RSVD_READ)
		else $error("reserved byte not sent as fixed");

endmodule // cgsr_regs_top

`default_nettype wire

/* shared/cgsr_pkg.sv */
// Package: indices, field positions, reset values and states of the config register bank
package cgsr_pkg;

	// Byte indices reached through the serial index pointer
	localparam logic [7:0] IDX_OUT_ENABLE = 8'h00;
	localparam logic [7:0] IDX_SPREAD_AMP = 8'h01;
	localparam logic [7:0] IDX_DIFF_SLEW = 8'h02;
	localparam logic [7:0] IDX_REF_CTRL = 8'h03;
	localparam logic [7:0] IDX_RSVD_FOUR = 8'h04;
	localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
	localparam logic [7:0] IDX_DEV_TYPE = 8'h06;
	localparam logic [7:0] IDX_BLOCK_LEN = 8'h07;

	// Field positions, spread and amplitude byte
	localparam int SPREAD_RB_HI = 7;
	localparam int SPREAD_RB_LO = 6;
	localparam int SPREAD_OVR_POS = 5;
	localparam int SPREAD_SOFT_HI = 4;
	localparam int SPREAD_SOFT_LO = 3;
	localparam int AMP_HI = 1;
	localparam int AMP_LO = 0;

	// Field positions, reference control byte
	localparam int REF_SLEW_HI = 7;
	localparam int REF_SLEW_LO = 6;
	localparam int REF_WOL_POS = 5;
	localparam int REF_OE_POS = 4;

	// Slew select bit position of each differential output 0..5
	localparam int NUM_DIFF = 6;
	localparam int DIFF_SLEW_POS [NUM_DIFF] = '{0, 2, 3, 4, 6, 7};

	// Values after reset
	localparam logic SPREAD_OVR_RST = 1'b0;
	localparam logic [1:0] SPREAD_SOFT_RST = 2'h0;
	localparam logic [1:0] AMP_RST = 2'h2;
	localparam logic DIFF_SLEW_RST = 1'b1;
	localparam logic [1:0] REF_SLEW_RST = 2'h1;
	localparam logic REF_WOL_RST = 1'b0;
	localparam logic REF_OE_RST = 1'b1;
	localparam logic [4:0] BLOCK_LEN_RST = 5'h08;

	// Fixed read values of reserved positions
	localparam logic SPREAD_RSVD_BIT = 1'b1;
	localparam logic [3:0] REF_RSVD_LOW = 4'hE;
	localparam logic [7:0] OUT_ENABLE_READ = 8'h00;
	localparam logic [7:0] RSVD_READ = 8'h00;

	// Serial byte framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Serial target states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_INDEX,
		ST_COUNT,
		ST_WDATA,
		ST_ACK,
		ST_TX,
		ST_HOSTACK,
		ST_TXNEXT,
		ST_WAIT
	} cgsr_state_e;

endpackage

/* hdl/cgsr_bus_edges.sv */
// Edge, start and stop detection on the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none

module cgsr_bus_edges (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial pins
	input wire logic sclIn,
	input wire logic sdaIn,
	// Detected events
	output logic sclRise,
	output logic sclFall,
	output logic startSeen,
	output logic stopSeen
);

	logic sclPrev_reg;
	logic sdaPrev_reg;

	// Previous pin levels
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclPrev_reg <= sclIn;
			sdaPrev_reg <= sdaIn;
		end
	end

	// Events: data moving while clock high marks start or stop
	assign sclRise = sclIn & ~sclPrev_reg;
	assign sclFall = ~sclIn & sclPrev_reg;
	assign startSeen = sclIn & sclPrev_reg & sdaPrev_reg & ~sdaIn;
	assign stopSeen = sclIn & sclPrev_reg & ~sdaPrev_reg & sdaIn;

endmodule // cgsr_bus_edges

`default_nettype wire

/* hdl/cgsr_reg_file.sv */
// Configuration and identification byte registers
`timescale 1ns/1ps
`default_nettype none

module cgsr_reg_file import cgsr_pkg::*; #(
	parameter logic [3:0] REV_IDENT = 4'h3, // Arbitrary value
	parameter logic [3:0] VENDOR_IDENT = 4'h5, // Arbitrary value
	parameter logic [1:0] DEV_TYPE = 2'h2, // Arbitrary value
	parameter logic [5:0] DEV_IDENT = 6'h2A // Arbitrary value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Write and read access
	input wire logic wrEn,
	input wire logic [7:0] wrIdx,
	input wire logic [7:0] wrData,
	input wire logic [7:0] rdIdx,
	output logic [7:0] rdData,
	// Latched strap
	input wire logic [1:0] spreadStrapReadback,
	// Field values
	output logic spreadSoftwareOverrideEn,
	output logic [1:0] spreadSoftSelect,
	output logic [1:0] amplitudeField,
	output logic [NUM_DIFF-1:0] diffSlewField,
	output logic [1:0] refSlewField,
	output logic wakeOnLanEn,
	output logic refOutputEn,
	output logic [4:0] blockReadLengthField
);

	logic [7:0] slewByte;

	// Spread and amplitude byte, strap and reserved bits not writable
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			spreadSoftwareOverrideEn <= SPREAD_OVR_RST;
			spreadSoftSelect <= SPREAD_SOFT_RST;
			amplitudeField <= AMP_RST;
		end else if (wrEn && wrIdx == IDX_SPREAD_AMP) begin
			spreadSoftwareOverrideEn <= wrData[SPREAD_OVR_POS]; // (R02)
			spreadSoftSelect <= wrData[SPREAD_SOFT_HI:SPREAD_SOFT_LO]; // (R04)
			amplitudeField <= wrData[AMP_HI:AMP_LO]; // (R05)
		end
	end

	// One slew select flop per differential output
	for (genvar g = 0; g < NUM_DIFF; g++) begin : gSlew
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				diffSlewField[g] <= DIFF_SLEW_RST;
			end else if (wrEn && wrIdx == IDX_DIFF_SLEW) begin
				diffSlewField[g] <= wrData[DIFF_SLEW_POS[g]]; // (R06)
			end
		end
	end

	// Reference control byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			refSlewField <= REF_SLEW_RST;
			wakeOnLanEn <= REF_WOL_RST;
			refOutputEn <= REF_OE_RST;
		end else if (wrEn && wrIdx == IDX_REF_CTRL) begin
			refSlewField <= wrData[REF_SLEW_HI:REF_SLEW_LO]; // (R07)
			wakeOnLanEn <= wrData[REF_WOL_POS]; // (R08)
			refOutputEn <= wrData[REF_OE_POS]; // (R09)
		end
	end

	// Block read length, upper bits reserved
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			blockReadLengthField <= BLOCK_LEN_RST;
		end else if (wrEn && wrIdx == IDX_BLOCK_LEN) begin
			blockReadLengthField <= wrData[4:0]; // (R10)
		end
	end

	// Slew byte assembly, reserved positions read zero
	always_comb begin
		slewByte = 8'h00;
		for (int i = 0; i < NUM_DIFF; i++) begin
			slewByte[DIFF_SLEW_POS[i]] = diffSlewField[i];
		end
	end

	// Read mux
	always_comb begin
		case (rdIdx)
			IDX_OUT_ENABLE: rdData = OUT_ENABLE_READ;
			IDX_SPREAD_AMP: rdData = {spreadStrapReadback, spreadSoftwareOverrideEn, // (R01)
				spreadSoftSelect, SPREAD_RSVD_BIT, amplitudeField}; // (R16)
			IDX_DIFF_SLEW: rdData = slewByte;
			IDX_REF_CTRL: rdData = {refSlewField, wakeOnLanEn, refOutputEn, REF_RSVD_LOW};
			IDX_RSVD_FOUR: rdData = RSVD_READ; // (R16)
			IDX_REV_VENDOR: rdData = {REV_IDENT, VENDOR_IDENT}; // (R11)
			IDX_DEV_TYPE: rdData = {DEV_TYPE, DEV_IDENT}; // (R12)
			IDX_BLOCK_LEN: rdData = {3'h0, blockReadLengthField};
			default: rdData = RSVD_READ;
		endcase
	end

endmodule // cgsr_reg_file

`default_nettype wire

/* dv/cgsr_host_model.sv */
// Serial bus host model: drives clock and data, resolves the open-drain data wire
`timescale 1ns/1ps
`default_nettype none

module cgsr_host_model (
	// Clock
	input wire logic clk,
	// Device data pin
	input wire logic devSdaOut,
	input wire logic devSdaOe,
	// Resolved bus levels
	output logic sclIn,
	output logic sdaIn
);
	logic sclDrv = 1'b1;
	logic sdaDrv = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// Pull-up wire, low while either party pulls it down
	assign sclIn = sclDrv;
	assign sdaIn = sdaDrv & ~(devSdaOe & ~devSdaOut);

	////////////////////////////////////////////////////////////////////////////////
	// Wait a number of clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Start, also used as repeated start
	task automatic start();
		sclDrv <= 1'b0;
		tick(2);
		sdaDrv <= 1'b1;
		tick(2);
		sclDrv <= 1'b1;
		tick(4);
		sdaDrv <= 1'b0;
		tick(4);
	endtask

	// Stop: data rises while the clock is high
	task automatic stop();
		sclDrv <= 1'b0;
		tick(2);
		sdaDrv <= 1'b0;
		tick(2);
		sclDrv <= 1'b1;
		tick(4);
		sdaDrv <= 1'b1;
		tick(4);
	endtask

	// Eight bits MSB first plus the ninth acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic hostAck, output logic [7:0] rd,
		output logic ack);
		logic [8:0] o;
		logic [8:0] i;
		o = {d, hostAck};
		for (int k = 8; k >= 0; k--) begin
			sclDrv <= 1'b0;
			tick(2);
			sdaDrv <= o[k];
			tick(2);
			sclDrv <= 1'b1;
			tick(2);
			i[k] = sdaIn;
			tick(2);
		end
		rd = i[8:1];
		ack = i[0];
	endtask
endmodule // cgsr_host_model

`default_nettype wire

/* dv/clock_gen_smbus_config_regs_tb.sv */
// Self-checking bench for the config register bank behind the serial target
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin nErrors++; $display("mismatch %s exp %h got %h", nm, ex, got); end end

module clock_gen_smbus_config_regs_tb;
	typedef struct {
		logic [7:0] idx, wd, rd;
		logic [12:0] outs;
	} cgsr_row_s;

	logic clk = 1'b0;
	logic reset = 1'b1;
	logic addrStrap = 1'b1;
	logic [1:0] strapLvl = 2'h1;
	logic powerGood = 1'b1;
	logic scl, sda, sdaOut, sdaOe, refRunning, nak, x;
	logic [1:0] spreadSel, amplitudeSel, refSlewSel;
	logic [5:0] diffSlewFast;
	logic [7:0] cnt, r;
	logic [7:0] got [8];
	logic [7:0] rstVal [7] = '{8'hC6, 8'hDD, 8'h5E, 8'h00, 8'h35, 8'hAA, 8'h08};
	int nErrors = 0;
	int testsRun = 0;
	// Outputs as {spread, amplitude, diff slew, ref slew, ref running}
	cgsr_row_s rows [18] = '{
		'{8'h01, 8'h00, 8'h44, {2'h1, 2'h0, 6'h3F, 2'h1, 1'h1}},
		'{8'h01, 8'hFF, 8'h7F, {2'h3, 2'h3, 6'h3F, 2'h1, 1'h1}},
		'{8'h01, 8'h10, 8'h54, {2'h1, 2'h0, 6'h3F, 2'h1, 1'h1}},
		'{8'h01, 8'h31, 8'h75, {2'h2, 2'h1, 6'h3F, 2'h1, 1'h1}},
		'{8'h01, 8'h2A, 8'h6E, {2'h1, 2'h2, 6'h3F, 2'h1, 1'h1}},
		'{8'h01, 8'h23, 8'h67, {2'h0, 2'h3, 6'h3F, 2'h1, 1'h1}},
		'{8'h02, 8'h00, 8'h00, {2'h0, 2'h3, 6'h00, 2'h1, 1'h1}},
		'{8'h02, 8'hFF, 8'hDD, {2'h0, 2'h3, 6'h3F, 2'h1, 1'h1}},
		'{8'h02, 8'h94, 8'h94, {2'h0, 2'h3, 6'h2A, 2'h1, 1'h1}},
		'{8'h03, 8'h00, 8'h0E, {2'h0, 2'h3, 6'h2A, 2'h0, 1'h0}},
		'{8'h03, 8'hF1, 8'hFE, {2'h0, 2'h3, 6'h2A, 2'h3, 1'h1}},
		'{8'h03, 8'h80, 8'h8E, {2'h0, 2'h3, 6'h2A, 2'h2, 1'h0}},
		'{8'h03, 8'h50, 8'h5E, {2'h0, 2'h3, 6'h2A, 2'h1, 1'h1}},
		'{8'h00, 8'hFF, 8'h00, {2'h0, 2'h3, 6'h2A, 2'h1, 1'h1}},
		'{8'h04, 8'hFF, 8'h00, {2'h0, 2'h3, 6'h2A, 2'h1, 1'h1}},
		'{8'h05, 8'h00, 8'h35, {2'h0, 2'h3, 6'h2A, 2'h1, 1'h1}},
		'{8'h06, 8'h00, 8'hAA, {2'h0, 2'h3, 6'h2A, 2'h1, 1'h1}},
		'{8'h07, 8'hE5, 8'h05, {2'h0, 2'h3, 6'h2A, 2'h1, 1'h1}}
	};

	////////////////////////////////////////////////////////////////////////////////
	// Clock and instances
	always #50 clk = ~clk;

	cgsr_regs_top cgsr_regs_top_i (
		.clk(clk), .reset(reset), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.targetAddressStrap(addrStrap), .spreadStrapLevel(strapLvl),
		.powerGoodPowerdownInput(powerGood), .spreadSel(spreadSel), .amplitudeSel(amplitudeSel),
		.diffSlewFast(diffSlewFast), .refSlewSel(refSlewSel), .refRunning(refRunning)
	);

	cgsr_host_model cgsr_host_model_i (
		.clk(clk), .devSdaOut(sdaOut), .devSdaOe(sdaOe), .sclIn(scl), .sdaIn(sda)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus helpers; nak gathers any refused byte
	task automatic put(input logic [7:0] d);
		cgsr_host_model_i.xfer(d, 1'b1, r, x);
		nak = nak | x;
	endtask

	// Block write of one data byte
	task automatic wr(input logic [6:0] a, input logic [7:0] n, input logic [7:0] d);
		nak = 1'b0;
		cgsr_host_model_i.start();
		put({a, 1'b0});
		put(n);
		put(8'h01);
		put(d);
		cgsr_host_model_i.stop();
	endtask

	// Block read of k bytes from index n, last one refused by the host
	task automatic rdBlk(input logic [6:0] a, input logic [7:0] n, input int k);
		nak = 1'b0;
		cgsr_host_model_i.start();
		put({a, 1'b0});
		put(n);
		cgsr_host_model_i.start();
		put({a, 1'b1});
		cgsr_host_model_i.xfer(8'hFF, 1'b0, cnt, x);
		for (int i = 0; i < k; i++) begin
			cgsr_host_model_i.xfer(8'hFF, (i == k - 1), got[i], x);
		end
		cgsr_host_model_i.stop();
	endtask

	// Compare the analog control outputs
	task automatic chkOut(input logic [12:0] e);
		`CHK("outputs", e, {spreadSel, amplitudeSel, diffSlewFast, refSlewSel, refRunning})
	endtask

	// Verdict and end of run
	task automatic completeRun();
		if (nErrors == 0 && testsRun > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		chkOut({2'h1, 2'h2, 6'h3F, 2'h1, 1'h1});
		foreach (rows[i]) begin
			wr(7'h31, rows[i].idx, rows[i].wd);
			`CHK("writeAck", 1'b0, nak)
			rdBlk(7'h31, rows[i].idx, 1);
			`CHK("count", (rows[i].idx == 8'h07) ? 8'h05 : 8'h08, cnt)
			`CHK("readByte", rows[i].rd, got[0])
			chkOut(rows[i].outs);
		end
		// Straps move after latching: new address 0x30 is refused
		addrStrap <= 1'b0;
		strapLvl <= 2'h3;
		wr(7'h30, 8'h03, 8'h00);
		`CHK("newAddrNak", 1'b1, nak)
		chkOut({2'h0, 2'h3, 6'h2A, 2'h1, 1'h1});
		// Count of one with a second data byte that must be refused
		nak = 1'b0;
		cgsr_host_model_i.start();
		put(8'h62);
		put(8'h02);
		put(8'h01);
		put(8'h00);
		`CHK("inCount", 1'b0, nak)
		put(8'hFF);
		`CHK("pastCount", 1'b1, nak)
		cgsr_host_model_i.stop();
		chkOut({2'h0, 2'h3, 6'h00, 2'h1, 1'h1});
		// Power down with and without wake-on-LAN
		powerGood <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK("refStopped", 1'b0, refRunning)
		wr(7'h31, 8'h03, 8'h70);
		`CHK("refWake", 1'b1, refRunning)
		// Reset in mid-run with power down: no answer until straps latch again
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		wr(7'h30, 8'h03, 8'h00);
		`CHK("preLatchNak", 1'b1, nak)
		powerGood <= 1'b1;
		repeat (4) @(posedge clk);
		chkOut({2'h3, 2'h2, 6'h3F, 2'h1, 1'h1});
		rdBlk(7'h30, 8'h01, 7);
		`CHK("rstAddrAck", 1'b0, nak)
		`CHK("rstCount", 8'h08, cnt)
		foreach (rstVal[i]) `CHK("rstByte", rstVal[i], got[i])
		completeRun();
	end

	// Watchdog against a hung bus
	initial begin
		repeat (60000) @(posedge clk);
		nErrors++;
		completeRun();
	end
endmodule // clock_gen_smbus_config_regs_tb

`default_nettype wire
